// file: core/dsd_map.vh
// Address map and timing constants of the data space decoder
`ifndef DSD_MAP_VH
`define DSD_MAP_VH

// ------------------------------------------------------------
// Data space regions
// ------------------------------------------------------------
`define DSD_REG_BASE    16'h0000
`define DSD_REG_SIZE    16'h0020
`define DSD_IO_BASE     16'h0020
`define DSD_IO_SIZE     16'h0040
`define DSD_XIO_BASE    16'h0060
`define DSD_XIO_SIZE    16'h00a0
`define DSD_SRAM_BASE   16'h0100
`define DSD_SRAM_SIZE   16'h0200
`define DSD_SRAM_LAST   16'h02ff

// ------------------------------------------------------------
// Pointer pair positions in the register file
// ------------------------------------------------------------
`define DSD_PTR_X_LO    5'h1a
`define DSD_PTR_Y_LO    5'h1c
`define DSD_PTR_Z_LO    5'h1e

// ------------------------------------------------------------
// Addressing modes
// ------------------------------------------------------------
`define DSD_MODE_DIRECT 3'h0
`define DSD_MODE_DISP   3'h1
`define DSD_MODE_IND    3'h2
`define DSD_MODE_PREDEC 3'h3
`define DSD_MODE_POSTINC 3'h4

// ------------------------------------------------------------
// Pointer select codes
// ------------------------------------------------------------
`define DSD_PSEL_X      2'h0
`define DSD_PSEL_Y      2'h1
`define DSD_PSEL_Z      2'h2

// ------------------------------------------------------------
// Limits and timing
// ------------------------------------------------------------
`define DSD_DISP_MAX    6'h3f
`define DSD_SRAM_CYCLES 2'h2

`endif

// file: core/dsd_data_space_decoder.v
// Data space decoder with register file, pointer modes, SRAM and program memory port
// Summary of operation
// - Addresses 0x00-0x1f select working registers
// - 64 addresses from 0x20 select standard I/O
// - 160 addresses from 0x60 select extended I/O
// - Addresses 0x100-0x2ff select 512-byte SRAM
// - Short I/O instructions reach only standard I/O
// - Direct addressing reaches the whole data space
// - Displacement up to 63 on X, Y or Z
// - Pre-decrement before, post-increment after access
// - R26-R31 form three 16-bit pointers
// - All regions reachable in all five modes
// - SRAM access completes in two cycles
// - Program memory is 16-bit words
// - Program store allowed from any address
// - Constant loads reach whole program memory
// - Every space linear, contiguous, no banking
// - Stack pointer resets to last SRAM address
`timescale 1ns/1ps
`default_nettype none
`include "dsd_map.vh"

module dsd_data_space_decoder #(
  parameter PM_AW = 13,
  parameter SRAM_DEPTH = 512
) (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  // Data access request from the core
  input  wire        i_req,
  input  wire        i_we,
  input  wire        i_io_short,
  input  wire [2:0]  i_mode,
  input  wire [1:0]  i_ptr_sel,
  input  wire [5:0]  i_disp,
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  // Stack pointer write from the core
  input  wire        i_sp_we,
  input  wire [15:0] i_sp_wdata,
  // Program memory port
  input  wire        i_pm_req,
  input  wire        i_pm_byte,
  input  wire        i_pm_we,
  input  wire        i_spm_en,
  input  wire [15:0] i_pm_addr,
  input  wire [15:0] i_pm_wdata,
  // Peripheral I/O side
  input  wire [7:0]  i_io_rdata,
  output reg         o_io_sel,
  output reg         o_xio_sel,
  output reg         o_io_we,
  output reg  [7:0]  o_io_addr,
  output reg  [7:0]  o_io_wdata,
  // Answers
  output reg         o_ack,
  output reg  [7:0]  o_rdata,
  output reg  [15:0] o_eff_addr,
  output reg         o_unmapped,
  output reg  [15:0] o_sp,
  output reg         o_pm_ack,
  output reg  [15:0] o_pm_rdata
);

  // ------------------------------------------------------------
  // Region decode
  // ------------------------------------------------------------
  // Region codes; everything past the SRAM is a hole
  localparam RG_REG  = 3'h0;
  localparam RG_IO   = 3'h1;
  localparam RG_XIO  = 3'h2;
  localparam RG_SRAM = 3'h3;
  localparam RG_NONE = 3'h4;

  // Ordered compares make the regions abut with no gap or overlap;
  // only the base of the next region is needed, and for the SRAM its last address
  function [2:0] dsd_region;
    input [15:0] a;
    begin
      if (a < `DSD_IO_BASE)
        dsd_region = RG_REG;
      else if (a < `DSD_XIO_BASE)
        dsd_region = RG_IO;
      else if (a < `DSD_SRAM_BASE)
        dsd_region = RG_XIO;
      else if (a <= `DSD_SRAM_LAST)
        dsd_region = RG_SRAM;
      else
        dsd_region = RG_NONE;
    end
  endfunction

  // Sequencer states; the SRAM index width follows the array depth
  localparam ST_IDLE = 1'b0;
  localparam ST_SRAM = 1'b1;
  localparam SRAM_AW = $clog2(SRAM_DEPTH);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Working registers, data SRAM and program memory words
  reg [7:0]         regf_r [0:31];
  reg [7:0]         sram_r [0:SRAM_DEPTH-1];
  reg [15:0]        pmem_r [0:(1<<PM_AW)-1];

  // A taken SRAM request is parked here for its second cycle
  reg               state_r;
  reg [SRAM_AW-1:0] hold_addr_r;
  reg               hold_we_r;
  reg [7:0]         hold_wdata_r;

  // ------------------------------------------------------------
  // Pointer selection and effective address
  // ------------------------------------------------------------
  reg  [4:0]  ptr_lo;
  reg  [15:0] ptr_val;
  reg  [15:0] eff;
  reg  [15:0] ptr_nxt;
  reg         ptr_upd;
  wire [2:0]  reg_code;
  wire [15:0] sram_off;

  // Pointer pairs live in the top six working registers
  always @* begin
    case (i_ptr_sel)
      `DSD_PSEL_Y: ptr_lo = `DSD_PTR_Y_LO;
      `DSD_PSEL_Z: ptr_lo = `DSD_PTR_Z_LO;
      default:     ptr_lo = `DSD_PTR_X_LO;
    endcase
    ptr_val = {regf_r[ptr_lo + 5'h01], regf_r[ptr_lo]};
  end

  // Plain 16-bit arithmetic keeps the space linear, no banking
  always @* begin
    ptr_nxt = ptr_val;
    ptr_upd = 1'b0;
    // Effective address per mode; pre-decrement uses the new value
    case (i_mode)
      `DSD_MODE_DIRECT: eff = i_addr;
      `DSD_MODE_DISP:   eff = ptr_val + {10'h000, i_disp};
      `DSD_MODE_IND:    eff = ptr_val;
      `DSD_MODE_PREDEC: begin
        eff     = ptr_val - 16'h0001;
        ptr_nxt = eff;
        ptr_upd = 1'b1;
      end
      `DSD_MODE_POSTINC: begin
        eff     = ptr_val;
        ptr_nxt = ptr_val + 16'h0001;
        ptr_upd = 1'b1;
      end
      default: eff = i_addr;
    endcase
    // Short I/O forms carry a 6-bit I/O number, offset into standard I/O;
    // they never touch a pointer, whatever the mode lines say, so the
    // extended region stays out of their reach
    if (i_io_short) begin
      eff     = `DSD_IO_BASE + {10'h000, i_addr[5:0]};
      ptr_nxt = ptr_val;
      ptr_upd = 1'b0;
    end
  end

  // Region of the effective address and its offset into the SRAM
  assign reg_code = dsd_region(eff);
  assign sram_off = eff - `DSD_SRAM_BASE;

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  // Register and I/O accesses answer next cycle; SRAM takes a second
  // cycle so the array read can be registered, trading latency for timing
  // Loop index for clearing the register file
  integer k;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r      <= ST_IDLE;
      hold_addr_r  <= {SRAM_AW{1'b0}};
      hold_we_r    <= 1'b0;
      hold_wdata_r <= 8'h00;
      o_ack        <= 1'b0;
      o_rdata      <= 8'h00;
      o_eff_addr   <= 16'h0000;
      o_unmapped   <= 1'b0;
      o_io_sel     <= 1'b0;
      o_xio_sel    <= 1'b0;
      o_io_we      <= 1'b0;
      o_io_addr    <= 8'h00;
      o_io_wdata   <= 8'h00;
      o_sp         <= `DSD_SRAM_LAST;
      // Register file cleared; SRAM and program memory keep their contents
      for (k = 0; k < 32; k = k + 1)
        regf_r[k] <= 8'h00;
    end else begin
      // Strobes are one-cycle pulses unless set again below
      o_ack     <= 1'b0;
      o_io_sel  <= 1'b0;
      o_xio_sel <= 1'b0;
      o_io_we   <= 1'b0;
      // The core may load the stack pointer in any cycle
      if (i_sp_we)
        o_sp <= i_sp_wdata;
      case (state_r)
        ST_IDLE: begin
          if (i_req) begin
            o_eff_addr <= eff;
            o_unmapped <= (reg_code == RG_NONE);
            // Pointer write-back at the take edge; a data write to the
            // same register further down is later and so wins
            if (ptr_upd) begin
              regf_r[ptr_lo]         <= ptr_nxt[7:0];
              regf_r[ptr_lo + 5'h01] <= ptr_nxt[15:8];
            end
            // Registers and I/O answer next cycle, SRAM parks the request
            case (reg_code)
              RG_REG: begin
                // A read returns the value from before any write
                if (i_we)
                  regf_r[eff[4:0]] <= i_wdata;
                o_rdata <= regf_r[eff[4:0]];
                o_ack   <= 1'b1;
              end
              // Peripheral read data is taken in the request cycle
              RG_IO, RG_XIO: begin
                o_io_sel   <= (reg_code == RG_IO);
                o_xio_sel  <= (reg_code == RG_XIO);
                o_io_we    <= i_we;
                o_io_addr  <= eff[7:0];
                o_io_wdata <= i_wdata;
                o_rdata    <= i_io_rdata;
                o_ack      <= 1'b1;
              end
              RG_SRAM: begin
                hold_addr_r  <= sram_off[SRAM_AW-1:0];
                hold_we_r    <= i_we;
                hold_wdata_r <= i_wdata;
                state_r      <= ST_SRAM;
              end
              default: begin
                // Holes: writes dropped, reads give zero
                o_rdata <= 8'h00;
                o_ack   <= 1'b1;
              end
            endcase
          end
        end
        // Second cycle: a request seen now is dropped without notice
        ST_SRAM: begin
          o_rdata <= sram_r[hold_addr_r];
          o_ack   <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // SRAM array has no reset; written in the second access cycle
  // from the parked copy, so the core may change its lines meanwhile
  always @(posedge i_sys_clk) begin
    if (state_r == ST_SRAM && hold_we_r)
      sram_r[hold_addr_r] <= hold_wdata_r;
  end

  // ------------------------------------------------------------
  // Program memory port
  // ------------------------------------------------------------
  // Word fetch or byte constant read; the byte address bit 0 picks
  // the high or low byte. Stores need only the enable, no section check
  wire [PM_AW-1:0] pm_word;
  wire [7:0]       pm_lane;
  assign pm_word = i_pm_byte ? i_pm_addr[PM_AW:1] : i_pm_addr[PM_AW-1:0];

  // Odd byte addresses take the high byte of the word
  assign pm_lane = i_pm_addr[0] ? pmem_r[pm_word][15:8] : pmem_r[pm_word][7:0];

  // A store lands only with the enable set; the address is not checked
  // against any section, so code anywhere may rewrite any word
  always @(posedge i_sys_clk) begin
    if (i_pm_req && i_pm_we && i_spm_en)
      pmem_r[pm_word] <= i_pm_wdata;
  end

  // Every program request is answered next cycle; reads also load the data
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pm_ack   <= 1'b0;
      o_pm_rdata <= 16'h0000;
    end else begin
      o_pm_ack <= i_pm_req;
      if (i_pm_req && !i_pm_we) begin
        if (i_pm_byte)
          o_pm_rdata <= {8'h00, pm_lane};
        else
          o_pm_rdata <= pmem_r[pm_word];
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/dsd_core_model.sv
// Load/store side of the core as seen by the data space decoder
`timescale 1ns/1ps
`default_nettype none
module dsd_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [7:0]  i_rdata,
  output var  logic        o_req = 1'b0,
  output var  logic        o_we = 1'b0,
  output var  logic        o_io_short = 1'b0,
  output var  logic [2:0]  o_mode = 3'h0,
  output var  logic [1:0]  o_ptr_sel = 2'h0,
  output var  logic [5:0]  o_disp = 6'h0,
  output var  logic [15:0] o_addr = 16'h0,
  output var  logic [7:0]  o_wdata = 8'h0
);
  // One request pulse, then a bounded wait for the answer; no overlap after SRAM
  task automatic access(input logic w, s, input logic [2:0] m, input logic [1:0] p,
                        input logic [5:0] d, input logic [15:0] a, input logic [7:0] v,
                        output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    @(posedge i_clk);
    o_req <= 1'b1;
    {o_we, o_io_short, o_mode, o_ptr_sel, o_disp, o_addr, o_wdata} <= {w, s, m, p, d, a, v};
    @(posedge i_clk);
    o_req <= 1'b0;
    // Released lines show garbage so stale values cannot be relied on
    {o_addr, o_wdata} <= ~{a, v};
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = i_ack;
      rd = i_rdata;
      if (!ok) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/dsd_chk.sv
// Port-level checks of the data space decoder
`timescale 1ns/1ps
`default_nettype none
module dsd_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_req,
  input wire logic        i_io_short,
  input wire logic [2:0]  i_mode,
  input wire logic [15:0] i_addr,
  input wire logic        i_pm_req,
  input wire logic        o_io_sel,
  input wire logic        o_xio_sel,
  input wire logic [7:0]  o_io_addr,
  input wire logic        o_ack,
  input wire logic [15:0] o_eff_addr,
  input wire logic        o_unmapped,
  input wire logic [15:0] o_sp,
  input wire logic        o_pm_ack
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire logic dir_req = i_req && !i_io_short && i_mode == 3'h0;
  // SRAM answers only on the second cycle
  sequence s_sram_wait;
    !o_ack ##1 o_ack;
  endsequence
  sequence s_pm_pulse;
    o_pm_ack ##1 !o_pm_ack;
  endsequence
  a_reg_answer: assert property (dir_req && i_addr < 16'h0020 |=> o_ack && !o_io_sel && !o_xio_sel)
    else $error("register access answer wrong");
  a_io_region: assert property (dir_req && i_addr inside {[16'h0020:16'h005f]} |=> o_io_sel && !o_xio_sel && o_io_addr == $past(i_addr[7:0]))
    else $error("standard io select wrong");
  a_xio_region: assert property (dir_req && i_addr inside {[16'h0060:16'h00ff]} |=> o_xio_sel && !o_io_sel)
    else $error("extended io select wrong");
  a_sram_two: assert property (dir_req && i_addr inside {[16'h0100:16'h02ff]} |=> s_sram_wait)
    else $error("sram answer not on second cycle");
  a_short_io: assert property (i_req && i_io_short |=> o_io_sel && o_eff_addr == 16'h0020 + $past(i_addr[5:0]))
    else $error("short io address wrong");
  a_unmapped_ack: assert property (dir_req && i_addr > 16'h02ff |=> o_ack && o_unmapped && !o_io_sel)
    else $error("unmapped access not flagged");
  a_direct_eff: assert property (dir_req && i_addr < 16'h0100 |=> o_eff_addr == $past(i_addr) && !o_unmapped)
    else $error("direct address not passed");
  a_pm_answer: assert property (i_pm_req |=> s_pm_pulse)
    else $error("program memory answer wrong");
  a_sp_reset: assert property (@(posedge i_sys_clk) disable iff (1'b0) i_rst |=> o_sp == 16'h02ff)
    else $error("stack pointer reset value wrong");
endmodule
`default_nettype wire
bind dsd_data_space_decoder dsd_chk dsd_chk_i (.i_sys_clk, .i_rst, .i_req, .i_io_short, .i_mode,
  .i_addr, .i_pm_req, .o_io_sel, .o_xio_sel, .o_io_addr, .o_ack, .o_eff_addr, .o_unmapped,
  .o_sp, .o_pm_ack);

// file: tb/dsd_data_space_decoder_tb.sv
// Self-checking testbench of the data space decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("Error %0t got %h expected %h", $time, (a), (b)); end end
module dsd_data_space_decoder_tb;
  logic clk = 0, rst = 1, sp_we = 0, pm_req = 0, pm_byte = 0, pm_we = 0, spm_en = 0;
  logic [15:0] sp_wd = 0, pm_addr = 0, pm_wd = 0;
  logic [7:0]  io_rd = 8'h5a, rd;
  wire logic req, we, sh, ack, iosel, xsel, unm, pm_ack, iowe;
  wire logic [2:0] md;
  wire logic [1:0] ps;
  wire logic [5:0] dp;
  wire logic [7:0] wd, rdata, ioad, iowd;
  wire logic [15:0] ad, eff, sp, pm_rd;
  int mismatches = 0, samples_checked = 0;
  always #4 clk = ~clk;
  dsd_core_model dsd_core_model_i (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_req(req),
    .o_we(we), .o_io_short(sh), .o_mode(md), .o_ptr_sel(ps), .o_disp(dp), .o_addr(ad), .o_wdata(wd));
  dsd_data_space_decoder dsd_data_space_decoder_i (.i_sys_clk(clk), .i_rst(rst), .i_req(req),
    .i_we(we), .i_io_short(sh), .i_mode(md), .i_ptr_sel(ps), .i_disp(dp), .i_addr(ad),
    .i_wdata(wd), .i_sp_we(sp_we), .i_sp_wdata(sp_wd), .i_pm_req(pm_req), .i_pm_byte(pm_byte),
    .i_pm_we(pm_we), .i_spm_en(spm_en), .i_pm_addr(pm_addr), .i_pm_wdata(pm_wd),
    .i_io_rdata(io_rd), .o_io_sel(iosel), .o_xio_sel(xsel), .o_io_we(iowe), .o_io_addr(ioad),
    .o_io_wdata(iowd), .o_ack(ack), .o_rdata(rdata), .o_eff_addr(eff), .o_unmapped(unm),
    .o_sp(sp), .o_pm_ack(pm_ack), .o_pm_rdata(pm_rd));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic acc(input logic w, s, input logic [2:0] m, input logic [1:0] p,
                     input logic [5:0] d, input logic [15:0] a, input logic [7:0] v);
    logic ok;
    dsd_core_model_i.access(w, s, m, p, d, a, v, rd, ok);
    if (!ok) begin mismatches++; final_report(); end
  endtask
  task automatic pm(input logic w, e, b, input logic [15:0] a, d);
    @(posedge clk);
    {pm_req, pm_we, spm_en, pm_byte, pm_addr, pm_wd} <= {1'b1, w, e, b, a, d};
    @(posedge clk);
    pm_req <= 1'b0;
    #1 `CHK(pm_ack, 1'b1)
  endtask
  // Region edges written then read back; io reads come from the peripheral
  task automatic t_regions();
    logic [15:0] a [6] = '{16'h001f, 16'h0020, 16'h00ff, 16'h0100, 16'h02ff, 16'h0300};
    for (int k = 0; k < 6; k++) begin
      acc(1, 0, 3'h0, 2'h0, 6'h0, a[k], 8'h30 + k);
      `CHK(iosel, k == 1)
      `CHK(xsel, k == 2)
      `CHK(iowe, k == 1 || k == 2)
      if (k == 1 || k == 2) begin
        `CHK(ioad, a[k][7:0])
        `CHK(iowd, 8'h30 + k)
      end
      acc(0, 0, 3'h0, 2'h0, 6'h0, a[k], 8'h00);
      `CHK(rd, (k == 0 || k == 3 || k == 4) ? 8'h30 + k : (k == 5 ? 8'h00 : io_rd))
      `CHK(eff, a[k])
      `CHK(unm, k == 5)
    end
    $display("test regions done");
  endtask
  task automatic t_pointer();
    acc(1, 0, 3'h0, 2'h0, 6'h0, 16'h001c, 8'h80);
    acc(1, 0, 3'h0, 2'h0, 6'h0, 16'h001d, 8'h01);
    acc(1, 0, 3'h1, 2'h1, 6'h3f, 16'h0, 8'h3c);
    `CHK(eff, 16'h01bf)
    acc(0, 0, 3'h0, 2'h0, 6'h0, 16'h01bf, 8'h0);
    `CHK(rd, 8'h3c)
    acc(1, 0, 3'h4, 2'h1, 6'h0, 16'h0, 8'h11);
    `CHK(eff, 16'h0180)
    acc(0, 0, 3'h0, 2'h0, 6'h0, 16'h001c, 8'h0);
    `CHK(rd, 8'h81)
    acc(0, 0, 3'h3, 2'h1, 6'h0, 16'h0, 8'h0);
    `CHK(eff, 16'h0180)
    acc(0, 0, 3'h2, 2'h1, 6'h0, 16'h0, 8'h0);
    `CHK(rd, 8'h11)
    acc(0, 1, 3'h2, 2'h0, 6'h0, 16'hffbd, 8'h0);
    `CHK(eff, 16'h005d)
    // Z with displacement into SRAM, X pre-decrement into extended I/O
    acc(1, 0, 3'h0, 2'h0, 6'h0, 16'h001e, 8'h00);
    acc(1, 0, 3'h0, 2'h0, 6'h0, 16'h001f, 8'h02);
    acc(1, 0, 3'h1, 2'h2, 6'h05, 16'h0, 8'h77);
    `CHK(eff, 16'h0205)
    acc(0, 0, 3'h0, 2'h0, 6'h0, 16'h0205, 8'h0);
    `CHK(rd, 8'h77)
    acc(1, 0, 3'h0, 2'h0, 6'h0, 16'h001a, 8'h00);
    acc(1, 0, 3'h0, 2'h0, 6'h0, 16'h001b, 8'h01);
    acc(1, 0, 3'h3, 2'h0, 6'h0, 16'h0, 8'h5e);
    `CHK(xsel, 1'b1)
    `CHK(eff, 16'h00ff)
    acc(0, 0, 3'h0, 2'h0, 6'h0, 16'h001a, 8'h0);
    `CHK(rd, 8'hff)
    $display("test pointer done");
  endtask
  // Store without the enable must leave the word alone
  task automatic t_prog();
    pm(1, 1, 0, 16'h1fff, 16'hbeef);
    pm(1, 0, 0, 16'h1fff, 16'h1234);
    pm(0, 0, 0, 16'h1fff, 16'h0);
    `CHK(pm_rd, 16'hbeef)
    pm(0, 0, 1, 16'h3fff, 16'h0);
    `CHK(pm_rd[7:0], 8'hbe)
    $display("test program done");
  endtask
  task automatic t_stack();
    `CHK(sp, 16'h02ff)
    @(posedge clk);
    {sp_we, sp_wd} <= {1'b1, 16'h0123};
    @(posedge clk);
    {sp_we, rst} <= 2'b01;
    #1 `CHK(sp, 16'h0123)
    @(posedge clk);
    rst <= 1'b0;
    #1 `CHK(sp, 16'h02ff)
    $display("test stack done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regions();
    t_pointer();
    t_prog();
    t_stack();
    final_report();
  end
endmodule
`default_nettype wire
